// File: src/adcseq_clkdiv.v
// conversion clock tick generator: divided system clock or rc clock edge
`include "adcseq_defs.vh"
`default_nettype none
module adcseq_clkdiv
(
  input  wire       clk,
  input  wire       arst_n,
  input  wire [2:0] sel,
  input  wire       rc_tick,
  output reg        tick
);
  reg [5:0] cnt_reg;
  reg [5:0] lim;
  always @*
  begin
    case (sel)
      3'h0:    lim = 6'h01;
      3'h1:    lim = 6'h07;
      3'h2:    lim = 6'h1F;
      3'h4:    lim = 6'h03;
      3'h5:    lim = 6'h0F;
      3'h6:    lim = 6'h3F;
      default: lim = 6'h00;
    endcase
  end
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_reg <= 6'h00;
      tick    <= 1'b0;
    end
    else if (sel == `ADCSEQ_CS_RC)
    begin
      cnt_reg <= 6'h00;
      tick    <= rc_tick;
    end
    else if (cnt_reg >= lim)
    begin
      cnt_reg <= 6'h00;
      tick    <= 1'b1;
    end
    else
    begin
      cnt_reg <= cnt_reg + 6'h01;
      tick    <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: src/adcseq_defs.vh
// register map, field positions and reset values of the conversion sequencer
`ifndef ADCSEQ_DEFS_VH
`define ADCSEQ_DEFS_VH
`define ADCSEQ_OFF_CTRL0    8'h00
`define ADCSEQ_OFF_CTRL1    8'h04
`define ADCSEQ_OFF_TRIG     8'h08
`define ADCSEQ_OFF_RESH     8'h0C
`define ADCSEQ_OFF_RESL     8'h10
`define ADCSEQ_OFF_IRQ_STAT 8'h14
`define ADCSEQ_OFF_IRQ_MASK 8'h18
`define ADCSEQ_OFF_STATUS   8'h1C
`define ADCSEQ_CTRL0_ON     0
`define ADCSEQ_CTRL0_GO     1
`define ADCSEQ_CTRL1_FMT    7
`define ADCSEQ_CTRL1_CS_HI  6
`define ADCSEQ_CTRL1_CS_LO  4
`define ADCSEQ_CTRL1_WMASK  8'hF7
`define ADCSEQ_CS_RC        3'h3
`define ADCSEQ_TRIG_NONE    5'h00
`define ADCSEQ_TRIG_SRCS    17
`define ADCSEQ_CTRL_RST     8'h00
`define ADCSEQ_CONV_CYCLES  12
`endif

// File: src/adcseq_top.v
// conversion sequencer with wishbone registers and interrupt
//
// Local design decisions: the Wishbone slave port and the register addresses.
`include "adcseq_defs.vh"
`default_nettype none
// Summary of operation
// - converter runs only while converter_on set
// - writing go starts a conversion when on
// - done clears go, flags, loads result
// - reset restores registers, aborts conversion
// - sleep conversions only with rc clock
// - rc clock delays start one instruction
// - done in sleep with interrupt wakes
// - done in sleep without interrupt powers down
// - sleep on non-rc clock aborts, powers down
// - rising trigger edge sets go
// - five-bit field picks trigger source
// - seventeen timer, comparator, logic, capture sources
module adcseq_top
#(
  parameter CONV_CYCLES = `ADCSEQ_CONV_CYCLES,
  parameter RES_W       = 10
)
(
  input  wire        CLK,
  input  wire        ARST_N,
  input  wire        WB_CYC_I,
  input  wire        WB_STB_I,
  input  wire        WB_WE_I,
  input  wire [7:0]  WB_ADR_I,
  input  wire [3:0]  WB_SEL_I,
  input  wire [31:0] WB_DAT_I,
  output reg  [31:0] WB_DAT_O,
  output reg         WB_ACK_O,
  input  wire [16:0] TRIG_SRC,
  input  wire        SLEEP_EXEC,
  input  wire        IN_SLEEP,
  input  wire        INSTR_TICK,
  input  wire        RC_TICK,
  input  wire [9:0]  CORE_RESULT,
  output reg         CORE_POWER,
  output reg         CORE_SAMPLE,
  output reg         WAKE,
  output reg         IRQ
);
  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_CONV = 2'h2;
  reg  [1:0]  state_reg;
  reg  [1:0]  state_next;
  reg         on_reg;
  reg         go_reg;
  reg         pdown_reg;
  reg  [7:0]  ctrl1_reg;
  reg  [4:0]  trig_reg;
  reg  [7:0]  resh_reg;
  reg  [7:0]  resl_reg;
  reg  [1:0]  stat_reg;
  reg  [1:0]  mask_reg;
  reg         trig_q_reg;
  reg  [7:0]  cnt_reg;
  reg  [31:0] rdata;
  wire        conv_tick;
  wire        wr;
  wire        rd_strobe;
  wire [2:0]  clk_sel;
  wire        rc_sel;
  wire        trig_lvl;
  wire        trig_rise;
  wire        active;
  wire        done;
  wire        abort;
  wire        go_wr;
  wire        start_ok;
  wire [15:0] res_al;
  // ****************************************
  // bus decode
  // ****************************************
  assign wr        = WB_CYC_I & WB_STB_I & WB_WE_I & ~WB_ACK_O & WB_SEL_I[0];
  assign rd_strobe = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  assign clk_sel   = ctrl1_reg[`ADCSEQ_CTRL1_CS_HI:`ADCSEQ_CTRL1_CS_LO];
  assign rc_sel    = (clk_sel == `ADCSEQ_CS_RC);
  function trig_pick;
    input [4:0]  sel;
    input [16:0] src;
    begin
      if (sel == `ADCSEQ_TRIG_NONE || sel > `ADCSEQ_TRIG_SRCS)
        trig_pick = 1'b0;
      else
        trig_pick = src[sel - 5'h01];
    end
  endfunction
  assign trig_lvl  = trig_pick(trig_reg, TRIG_SRC);
  assign trig_rise = trig_lvl & ~trig_q_reg;
  assign active    = (state_reg != ST_IDLE);
  assign go_wr     = wr && WB_ADR_I == `ADCSEQ_OFF_CTRL0 &&
                     WB_DAT_I[`ADCSEQ_CTRL0_GO];
  // on must already be set before the write that sets go
  assign start_ok  = on_reg & ~pdown_reg;
  assign abort     = active & SLEEP_EXEC & ~rc_sel;
  assign done      = (state_reg == ST_CONV) & conv_tick &
                     (cnt_reg == CONV_CYCLES[7:0] - 8'h01) & ~abort;
  assign res_al    = ctrl1_reg[`ADCSEQ_CTRL1_FMT] ?
                     {6'h00, CORE_RESULT} : {CORE_RESULT, 6'h00};
  adcseq_clkdiv u_div
  (
    .clk     (CLK),
    .arst_n  (ARST_N),
    .sel     (clk_sel),
    .rc_tick (RC_TICK),
    .tick    (conv_tick)
  );
  // ****************************************
  // sequencer
  // ****************************************
  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
        if (start_ok && !active && (go_wr || trig_rise))
          state_next = rc_sel ? ST_WAIT : ST_CONV;
      ST_WAIT:
        if (!on_reg || abort)
          state_next = ST_IDLE;
        else if (INSTR_TICK)
          state_next = ST_CONV;
      ST_CONV:
        if (!on_reg || abort || done)
          state_next = ST_IDLE;
      default:
        state_next = ST_IDLE;
    endcase
  end
  always @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      state_reg  <= ST_IDLE;
      on_reg     <= 1'b0;
      go_reg     <= 1'b0;
      pdown_reg  <= 1'b0;
      ctrl1_reg  <= `ADCSEQ_CTRL_RST;
      trig_reg   <= `ADCSEQ_TRIG_NONE;
      resh_reg   <= 8'h00;
      resl_reg   <= 8'h00;
      stat_reg   <= 2'h0;
      mask_reg   <= 2'h0;
      trig_q_reg <= 1'b0;
      cnt_reg    <= 8'h00;
    end
    else
    begin
      state_reg  <= state_next;
      trig_q_reg <= trig_lvl;
      if (state_reg == ST_CONV && conv_tick)
        cnt_reg <= cnt_reg + 8'h01;
      else if (state_reg != ST_CONV)
        cnt_reg <= 8'h00;
      if (wr && WB_ADR_I == `ADCSEQ_OFF_CTRL0)
      begin
        on_reg <= WB_DAT_I[`ADCSEQ_CTRL0_ON];
        if (WB_DAT_I[`ADCSEQ_CTRL0_ON])
          pdown_reg <= 1'b0;
      end
      if (wr && WB_ADR_I == `ADCSEQ_OFF_CTRL1)
        ctrl1_reg <= WB_DAT_I[7:0] & `ADCSEQ_CTRL1_WMASK;
      if (wr && WB_ADR_I == `ADCSEQ_OFF_TRIG)
        trig_reg <= WB_DAT_I[4:0];
      if (wr && WB_ADR_I == `ADCSEQ_OFF_IRQ_MASK)
        mask_reg <= WB_DAT_I[1:0];
      if (state_next != ST_IDLE && state_reg == ST_IDLE)
        go_reg <= 1'b1;
      else if (state_next == ST_IDLE)
        go_reg <= 1'b0;
      if (done)
      begin
        resh_reg <= res_al[15:8];
        resl_reg <= res_al[7:0];
        if (IN_SLEEP && !mask_reg[0])
          pdown_reg <= 1'b1;
      end
      if (abort)
        pdown_reg <= 1'b1;
      // set wins over write-one-to-clear
      stat_reg[0] <= done |
        (stat_reg[0] & ~(wr && WB_ADR_I == `ADCSEQ_OFF_IRQ_STAT &&
                         WB_DAT_I[0]));
      stat_reg[1] <= abort |
        (stat_reg[1] & ~(wr && WB_ADR_I == `ADCSEQ_OFF_IRQ_STAT &&
                         WB_DAT_I[1]));
    end
  end
  // ****************************************
  // outputs
  // ****************************************
  always @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      CORE_POWER  <= 1'b0;
      CORE_SAMPLE <= 1'b0;
      WAKE        <= 1'b0;
      IRQ         <= 1'b0;
    end
    else
    begin
      CORE_POWER  <= on_reg & ~pdown_reg & ~abort;
      CORE_SAMPLE <= (state_next == ST_CONV) && (state_reg != ST_CONV);
      WAKE        <= done & IN_SLEEP & mask_reg[0];
      IRQ         <= |(stat_reg & mask_reg);
    end
  end
  always @*
  begin
    case (WB_ADR_I)
      `ADCSEQ_OFF_CTRL0:    rdata = {30'h0, go_reg, on_reg};
      `ADCSEQ_OFF_CTRL1:    rdata = {24'h0, ctrl1_reg};
      `ADCSEQ_OFF_TRIG:     rdata = {27'h0, trig_reg};
      `ADCSEQ_OFF_RESH:     rdata = {24'h0, resh_reg};
      `ADCSEQ_OFF_RESL:     rdata = {24'h0, resl_reg};
      `ADCSEQ_OFF_IRQ_STAT: rdata = {30'h0, stat_reg};
      `ADCSEQ_OFF_IRQ_MASK: rdata = {30'h0, mask_reg};
      `ADCSEQ_OFF_STATUS:   rdata = {28'h0, pdown_reg, active, state_reg};
      default:              rdata = 32'h0000_0000;
    endcase
  end
  always @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end
    else
    begin
      WB_ACK_O <= rd_strobe;
      WB_DAT_O <= rd_strobe ? rdata : 32'h0000_0000;
    end
  end
endmodule
`default_nettype wire

// File: verification/adcseq_properties.sv
// concurrent checks on the sequencer ports
`default_nettype none
module adcseq_props
(
  input wire logic        CLK,
  input wire logic        ARST_N,
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_ACK_O,
  input wire logic [31:0] WB_DAT_O,
  input wire logic        CORE_POWER,
  input wire logic        CORE_SAMPLE,
  input wire logic        WAKE,
  input wire logic        IRQ,
  input wire logic        IN_SLEEP
);
  // ****************
  // port checks
  // ****************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  property p_ack; WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O; endproperty
  a_ack: assert property (p_ack) else $error("ack late");
  property p_idle; !(WB_CYC_I && WB_STB_I) |=> !WB_ACK_O; endproperty
  a_idle: assert property (p_idle) else $error("ack without request");
  property p_dat; !WB_ACK_O |-> WB_DAT_O == 32'h0; endproperty
  a_dat: assert property (p_dat) else $error("data outside ack");
  property p_rst; $rose(ARST_N) |-> !CORE_POWER && !IRQ && !WAKE; endproperty
  a_rst: assert property (p_rst) else $error("outputs after reset");
  property p_pwr; CORE_SAMPLE |-> CORE_POWER; endproperty
  a_pwr: assert property (p_pwr) else $error("sample while off");
  property p_gap; CORE_SAMPLE |=> !CORE_SAMPLE [*8]; endproperty
  a_gap: assert property (p_gap) else $error("restart in conversion");
  property p_wake; WAKE |-> IN_SLEEP; endproperty
  a_wake: assert property (p_wake) else $error("wake while awake");
  property p_wirq; WAKE |=> IRQ && !WAKE; endproperty
  a_wirq: assert property (p_wirq) else $error("wake pulse or irq");
endmodule
bind adcseq_top adcseq_props u_props (.*);
`default_nettype wire

// File: verification/tb.sv
// self-checking bench for the conversion sequencer
`include "adcseq_defs.vh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************
  // stimulus and checks
  // ****************
  localparam logic [7:0] C0 = `ADCSEQ_OFF_CTRL0, C1 = `ADCSEQ_OFF_CTRL1;
  localparam logic [7:0] TS = `ADCSEQ_OFF_TRIG, ST = `ADCSEQ_OFF_IRQ_STAT;
  localparam logic [7:0] MK = `ADCSEQ_OFF_IRQ_MASK, RH = `ADCSEQ_OFF_RESH;
  localparam logic [7:0] RL = `ADCSEQ_OFF_RESL;
  logic        clk, rst_n, cyc, we, slx, slp, itk, rtk;
  logic        ack, pwr, smp, wk, irq, wk_seen;
  logic [7:0]  adr;
  logic [31:0] dat, dout;
  logic [16:0] trg;
  logic [9:0]  res;
  logic [7:0]  q[$];
  int          mismatches, cmp_count, tc, i;
  adcseq_top DUT
  (
    .CLK(clk), .ARST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(cyc),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(dat),
    .WB_DAT_O(dout), .WB_ACK_O(ack), .TRIG_SRC(trg), .SLEEP_EXEC(slx),
    .IN_SLEEP(slp), .INSTR_TICK(itk), .RC_TICK(rtk), .CORE_RESULT(res),
    .CORE_POWER(pwr), .CORE_SAMPLE(smp), .WAKE(wk), .IRQ(irq)
  );
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task wack;
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1)
    begin
      mismatches++;
      $display("[ERR] ack exp 1 got %b", ack);
    end
    cyc <= 1'b0;
    we <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    we <= 1'b1;
    adr <= a;
    dat <= {24'h0, d};
    wack;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    cyc <= 1'b1;
    adr <= a;
    q.push_back(e);
    wack;
  endtask
  task w_irq;
    int n;
    for (n = 0; n < 500 && irq !== 1'b1; n++) @(posedge clk);
    chk("irq", 8'h01, {7'h0, irq});
  endtask
  // read data checked against the oldest note
  always @(posedge clk)
    if (ack === 1'b1 && we === 1'b0)
      chk("rdata", q.pop_front(), dout[7:0]);
  always @(posedge clk)
    if (wk === 1'b1)
      wk_seen <= 1'b1;
  always @(posedge clk)
  begin
    tc <= tc + 1;
    itk <= (tc % 4 == 3);
    rtk <= ($urandom % 3 == 0);
  end
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial
  begin
    repeat (30000) @(posedge clk);
    mismatches++;
    give_verdict;
  end
  initial
  begin
    void'($urandom(32'h4A8DEC11));
    {rst_n, cyc, we, slx, slp, itk, rtk, wk_seen} = 8'h00;
    {adr, dat, trg, res} = '0;
    {mismatches, cmp_count, tc} = '0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 9; i++) rd(8'(i * 4), 8'h00);
    wr(C1, 8'h8F); rd(C1, 8'h87);
    wr(C1, 8'h00);
    wr(C0, 8'h02); rd(C0, 8'h00);
    wr(C0, 8'h03); rd(C0, 8'h01);
    wr(MK, 8'h01);
    res <= 10'($urandom);
    wr(C0, 8'h03); rd(C0, 8'h03);
    w_irq;
    rd(C0, 8'h01); rd(ST, 8'h01);
    rd(RH, res[9:2]); rd(RL, {res[1:0], 6'h00});
    chk("wake", 8'h00, {7'h0, wk_seen});
    wr(ST, 8'h01); rd(ST, 8'h00);
    chk("irq", 8'h00, {7'h0, irq});
    for (i = 1; i < 18; i++)
    begin
      wr(TS, 8'(i)); rd(TS, 8'(i));
      trg[i - 1] <= 1'b1;
      repeat (4) @(posedge clk);
      trg <= '0;
      repeat (2) @(posedge clk);
      trg[i - 1] <= 1'b1;
      w_irq;
      trg <= '0;
      wr(ST, 8'h01);
      repeat (40) @(posedge clk);
      rd(ST, 8'h00);
    end
    wr(TS, 8'h00);
    wr(C0, 8'h03);
    slx <= 1'b1;
    @(posedge clk);
    slx <= 1'b0;
    rd(ST, 8'h02); rd(C0, 8'h01);
    chk("pwr", 8'h00, {7'h0, pwr});
    wr(ST, 8'h03); wr(C0, 8'h01);
    wr(C1, 8'h30);
    slp <= 1'b1;
    wr(C0, 8'h03); rd(C0, 8'h03);
    w_irq;
    slp <= 1'b0;
    chk("wake", 8'h01, {7'h0, wk_seen});
    rd(ST, 8'h01);
    wr(ST, 8'h01); wr(MK, 8'h00);
    slp <= 1'b1;
    wr(C0, 8'h03);
    for (i = 0; i < 500 && pwr !== 1'b0; i++) @(posedge clk);
    chk("pwr", 8'h00, {7'h0, pwr});
    chk("irq", 8'h00, {7'h0, irq});
    slp <= 1'b0;
    rd(ST, 8'h01); rd(C0, 8'h01);
    wr(C0, 8'h01); wr(C0, 8'h03);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(C0, 8'h00); rd(C1, 8'h00);
    give_verdict;
  end
endmodule
`default_nettype wire
